// >>> pkg/vas_pkg.sv
package vas_pkg;
  localparam int LANES = 4;
  localparam int IN_W = 16;
  localparam int FULL_W = 17;
  localparam int OUT_W = 16;
  localparam int CALC_W = 20;
  localparam int LATENCY = 3;
  localparam bit MAX_PERF = 1'b0;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int CTRL_W = 11;

  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] COUNT_ADDR = 12'h008;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h000;
  localparam int STAT_FULL_BIT = 5;
  localparam int STAT_RDY_BIT = 6;
  localparam int STAT_OVF_BIT = 7;

  typedef enum logic [1:0] {
    VAS_OP_ADD = 2'b00,
    VAS_OP_SUB = 2'b01,
    VAS_OP_SEL = 2'b10
  } vas_op_e;

  typedef enum logic [1:0] {
    VAS_Q_TRUNC = 2'b00,
    VAS_Q_RND_INF = 2'b01,
    VAS_Q_RND_EVEN = 2'b10
  } vas_quant_e;

  typedef enum logic [1:0] {
    VAS_OV_WRAP = 2'b00,
    VAS_OV_SAT = 2'b01,
    VAS_OV_FLAG = 2'b10
  } vas_ovf_e;

  // Packs onto CTRL bits [10:0], op in the low bits
  typedef struct packed {
    logic in_signed;
    logic [1:0] drop;
    vas_ovf_e ovf;
    vas_quant_e quant;
    logic out_signed;
    logic user_prec;
    vas_op_e op;
  } vas_ctrl_s;

  typedef struct packed {
    logic [LANES-1:0] sub;
    logic [LANES-1:0] cin;
    logic [LANES-1:0][IN_W-1:0] a;
    logic [LANES-1:0][IN_W-1:0] b;
  } vas_in_s;

  typedef struct packed {
    logic [LANES-1:0] cout;
    logic [LANES-1:0][FULL_W-1:0] res;
  } vas_out_s;
endpackage

// >>> rtl/vas_top.sv
// Chosen here: the address map and register access over APB.

module vas_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  wire logic push = in_valid && in_ready;
  wire logic pop = out_valid && out_ready;

  assign in_ready = cnt_r != CW'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign count = cnt_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
endmodule // vas_fifo

module vas_top (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IN_VALID,
  output logic IN_READY,
  input wire vas_pkg::vas_in_s IN_DATA,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output vas_pkg::vas_out_s OUT_DATA
);
  localparam int NSH = vas_pkg::MAX_PERF ? vas_pkg::LATENCY - 1 : vas_pkg::LATENCY;
  localparam int OW = vas_pkg::FULL_W + 2;

  vas_pkg::vas_ctrl_s ctrl_r;
  logic ovf_seen_r;
  logic [31:0] done_cnt_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic pready_r;
  logic in_ready_r;
  logic out_valid_r;
  vas_pkg::vas_out_s out_data_r;
  vas_pkg::vas_in_s core_in;
  logic core_v;
  vas_pkg::vas_out_s core_out;
  logic [vas_pkg::LANES-1:0] core_ovf;
  vas_pkg::vas_out_s stage_r [NSH];
  logic [NSH-1:0] stage_v_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  vas_pkg::vas_out_s fifo_dout;
  logic [vas_pkg::CNT_W-1:0] fifo_cnt;

  wire logic acc = IN_VALID && in_ready_r;
  wire logic fifo_push = stage_v_r[NSH-1];
  wire logic fifo_pop = fifo_out_valid && (!out_valid_r || OUT_READY);
  wire logic apb_setup = PSEL && !PENABLE;
  wire logic apb_wr = PSEL && PENABLE && PWRITE && pready_r;

  function automatic logic mapped(input logic [11:0] addr);
    mapped = addr == vas_pkg::CTRL_ADDR || addr == vas_pkg::STATUS_ADDR || addr == vas_pkg::COUNT_ADDR;
  endfunction

  // Returns {ovf, cout, result} for one lane
  function automatic logic [OW-1:0] lane_calc(
    input logic [vas_pkg::IN_W-1:0] a,
    input logic [vas_pkg::IN_W-1:0] b,
    input logic sub_in,
    input logic cin,
    input vas_pkg::vas_ctrl_s c
  );
    logic signed [vas_pkg::CALC_W-1:0] ea;
    logic signed [vas_pkg::CALC_W-1:0] eb;
    logic signed [vas_pkg::CALC_W-1:0] v;
    logic signed [vas_pkg::CALC_W-1:0] q;
    logic signed [vas_pkg::CALC_W-1:0] half;
    logic signed [vas_pkg::CALC_W-1:0] hi;
    logic signed [vas_pkg::CALC_W-1:0] lo;
    logic [vas_pkg::OUT_W-1:0] r;
    logic sub;
    logic ov;
    logic co;
    logic [vas_pkg::FULL_W-1:0] res;
    ea = c.in_signed ? vas_pkg::CALC_W'(signed'(a)) : vas_pkg::CALC_W'({1'b0, a});
    eb = c.in_signed ? vas_pkg::CALC_W'(signed'(b)) : vas_pkg::CALC_W'({1'b0, b});
    sub = c.op == vas_pkg::VAS_OP_SUB || (c.op == vas_pkg::VAS_OP_SEL && sub_in == 1'b1);
    // Operands are integers, so carry-in only hinges on the precision mode
    v = (sub ? ea - eb : ea + eb) + vas_pkg::CALC_W'(c.user_prec & cin);
    half = c.drop == 2'h0 ? '0 : vas_pkg::CALC_W'(1) <<< (c.drop - 2'h1);
    if (c.drop == 2'h0) begin
      q = v;
    end else begin
      case (c.quant)
        // Every term stays signed at lane width so the shift keeps the sign
        vas_pkg::VAS_Q_RND_INF: q = v[vas_pkg::CALC_W-1] ? (v + half - vas_pkg::CALC_W'(1)) >>> c.drop
          : (v + half) >>> c.drop;
        vas_pkg::VAS_Q_RND_EVEN: q = (v + half - vas_pkg::CALC_W'(1)
          + signed'(vas_pkg::CALC_W'(v[c.drop]))) >>> c.drop;
        default: q = v >>> c.drop;
      endcase
    end
    hi = c.out_signed ? vas_pkg::CALC_W'(20'sh07fff) : vas_pkg::CALC_W'(20'sh0ffff);
    lo = c.out_signed ? vas_pkg::CALC_W'(20'shf8000) : '0;
    ov = q > hi || q < lo;
    if (ov && c.ovf == vas_pkg::VAS_OV_SAT) begin
      r = q > hi ? hi[vas_pkg::OUT_W-1:0] : lo[vas_pkg::OUT_W-1:0];
    end else begin
      // Flag mode keeps wrap hardware; the sticky bit is set on overflow in every ovf mode, wrap included
      r = q[vas_pkg::OUT_W-1:0];
    end
    // User precision only here; full precision mode bypasses this and stays full width
    if (c.user_prec) begin
      res = c.out_signed ? {r[vas_pkg::OUT_W-1], r} : {1'b0, r};
    end else begin
      res = v[vas_pkg::FULL_W-1:0];
      ov = 1'b0;
    end
    co = c.user_prec && !c.in_signed && !c.out_signed && c.drop == 2'h0 && v[vas_pkg::OUT_W];
    lane_calc = {ov, co, res};
  endfunction

  generate
    if (vas_pkg::MAX_PERF) begin : g_inreg
      vas_pkg::vas_in_s in_r;
      logic in_v_r;
      // Operand register inside the core; excess delay follows the output register
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          in_r <= '0;
          in_v_r <= 1'b0;
        end else begin
          in_r <= IN_DATA;
          in_v_r <= acc;
        end
      end
      assign core_in = in_r;
      assign core_v = in_v_r;
    end else begin : g_noreg
      assign core_in = IN_DATA;
      assign core_v = acc;
    end
  endgenerate

  genvar gi;
  generate
    for (gi = 0; gi < vas_pkg::LANES; gi++) begin : g_lane
      logic [OW-1:0] lr;
      assign lr = lane_calc(core_in.a[gi], core_in.b[gi], core_in.sub[gi], core_in.cin[gi], ctrl_r);
      assign core_out.res[gi] = lr[vas_pkg::FULL_W-1:0];
      assign core_out.cout[gi] = lr[vas_pkg::FULL_W];
      assign core_ovf[gi] = lr[vas_pkg::FULL_W+1];
    end
  endgenerate

  // Single output register after the arithmetic, then the delay line
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stage_r[0] <= '0;
      stage_v_r[0] <= 1'b0;
    end else begin
      stage_r[0] <= core_out;
      stage_v_r[0] <= core_v;
    end
  end

  genvar gk;
  generate
    for (gk = 1; gk < NSH; gk++) begin : g_delay
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          stage_r[gk] <= '0;
          stage_v_r[gk] <= 1'b0;
        end else begin
          stage_r[gk] <= stage_r[gk-1];
          stage_v_r[gk] <= stage_v_r[gk-1];
        end
      end
    end
  endgenerate

  vas_fifo #(
    .WIDTH($bits(vas_pkg::vas_out_s)),
    .DEPTH(vas_pkg::FIFO_DEPTH),
    .CW(vas_pkg::CNT_W)
  ) u_fifo (
    .clk(CLK),
    .rst(RST),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(stage_r[NSH-1]),
    .out_valid(fifo_out_valid),
    .out_ready(!out_valid_r || OUT_READY),
    .out_data(fifo_dout),
    .count(fifo_cnt)
  );

  // The pipeline cannot stall, so room for every sample in flight is reserved
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      in_ready_r <= 1'b0;
    end else begin
      in_ready_r <= 32'(fifo_cnt) + vas_pkg::LATENCY + 2 <= vas_pkg::FIFO_DEPTH;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (!out_valid_r || OUT_READY) begin
      out_valid_r <= fifo_out_valid;
      out_data_r <= fifo_dout;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_r <= vas_pkg::CTRL_RST;
    end else if (apb_wr && PADDR == vas_pkg::CTRL_ADDR) begin
      ctrl_r <= vas_pkg::vas_ctrl_s'(PWDATA[vas_pkg::CTRL_W-1:0]);
    end
  end

  // Write one clears; a new overflow in the same cycle wins
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ovf_seen_r <= 1'b0;
    end else if (core_v && |core_ovf) begin
      ovf_seen_r <= 1'b1;
    end else if (apb_wr && PADDR == vas_pkg::STATUS_ADDR && PWDATA[vas_pkg::STAT_OVF_BIT]) begin
      ovf_seen_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      done_cnt_r <= '0;
    end else if (out_valid_r && OUT_READY) begin
      done_cnt_r <= done_cnt_r + 32'h1;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (apb_setup) begin
        pslverr_r <= !mapped(PADDR);
        case (PADDR)
          vas_pkg::CTRL_ADDR: prdata_r <= 32'(ctrl_r);
          vas_pkg::STATUS_ADDR: prdata_r <= {24'h0, ovf_seen_r, in_ready_r,
            fifo_cnt == vas_pkg::CNT_W'(vas_pkg::FIFO_DEPTH), fifo_cnt};
          vas_pkg::COUNT_ADDR: prdata_r <= done_cnt_r;
          default: prdata_r <= '0;
        endcase
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PSLVERR = pslverr_r;
  assign PREADY = pready_r;
  assign IN_READY = in_ready_r;
  assign OUT_VALID = out_valid_r;
  assign OUT_DATA = out_data_r;

  localparam int LAT_A = vas_pkg::LATENCY;
  logic [vas_pkg::FULL_W-1:0] exp_add0;
  logic [vas_pkg::FULL_W-1:0] exp_sub0;
  assign exp_add0 = vas_pkg::FULL_W'(signed'(IN_DATA.a[0])) + vas_pkg::FULL_W'(signed'(IN_DATA.b[0]));
  assign exp_sub0 = vas_pkg::FULL_W'(signed'(IN_DATA.a[0])) - vas_pkg::FULL_W'(signed'(IN_DATA.b[0]));

  sequence s_lands;
    ##LAT_A fifo_push;
  endsequence

  sequence s_sgn_user(vas_pkg::vas_ovf_e ov, logic [1:0] dr, vas_pkg::vas_quant_e qm);
    acc && ctrl_r.user_prec && ctrl_r.out_signed && ctrl_r.in_signed && ctrl_r.op == vas_pkg::VAS_OP_ADD
      && ctrl_r.ovf == ov && ctrl_r.drop == dr && ctrl_r.quant == qm;
  endsequence

  a_fifo_no_overrun: assert property (@(posedge CLK) disable iff (RST) fifo_push |-> fifo_in_ready)
    else $error("result pushed into full buffer");
  a_lat_lands: assert property (@(posedge CLK) disable iff (RST) acc |-> s_lands)
    else $error("result not delivered after configured latency");
  a_lat_not_early: assert property (@(posedge CLK) disable iff (RST)
    acc && !$past(acc) && !$past(acc, 2) && !$past(acc, 3) |-> !fifo_push ##1 !fifo_push)
    else $error("result delivered early");
  a_full_add_exact: assert property (@(posedge CLK) disable iff (RST)
    acc && !ctrl_r.user_prec && ctrl_r.in_signed && ctrl_r.op == vas_pkg::VAS_OP_ADD
    |-> s_lands ##0 stage_r[NSH-1].res[0] == $past(exp_add0, LAT_A))
    else $error("full precision sum wrong");
  a_sel_subtract: assert property (@(posedge CLK) disable iff (RST)
    acc && !ctrl_r.user_prec && ctrl_r.in_signed && ctrl_r.op == vas_pkg::VAS_OP_SEL && IN_DATA.sub[0]
    |-> s_lands ##0 stage_r[NSH-1].res[0] == $past(exp_sub0, LAT_A))
    else $error("selected subtraction wrong");
  a_sat_top: assert property (@(posedge CLK) disable iff (RST)
    s_sgn_user(vas_pkg::VAS_OV_SAT, 2'h0, vas_pkg::VAS_Q_TRUNC) and (IN_DATA.a[0] == 16'h7fff
    && IN_DATA.b[0] == 16'h0001 && !IN_DATA.cin[0]) |-> s_lands ##0 stage_r[NSH-1].res[0] == 17'h07fff)
    else $error("saturation wrong");
  a_wrap_top: assert property (@(posedge CLK) disable iff (RST)
    s_sgn_user(vas_pkg::VAS_OV_FLAG, 2'h0, vas_pkg::VAS_Q_TRUNC) and (IN_DATA.a[0] == 16'h7fff
    && IN_DATA.b[0] == 16'h0001 && !IN_DATA.cin[0]) |-> s_lands ##0 stage_r[NSH-1].res[0] == 17'h18000)
    else $error("wrap wrong");
  a_round_even: assert property (@(posedge CLK) disable iff (RST)
    s_sgn_user(vas_pkg::VAS_OV_WRAP, 2'h1, vas_pkg::VAS_Q_RND_EVEN) and (IN_DATA.a[0] == 16'h0001
    && IN_DATA.b[0] == 16'h0000 && !IN_DATA.cin[0]) |-> s_lands ##0 stage_r[NSH-1].res[0] == 17'h00000)
    else $error("round to even wrong");
  a_round_away: assert property (@(posedge CLK) disable iff (RST)
    s_sgn_user(vas_pkg::VAS_OV_WRAP, 2'h1, vas_pkg::VAS_Q_RND_INF) and (IN_DATA.a[0] == 16'hffff
    && IN_DATA.b[0] == 16'h0000 && !IN_DATA.cin[0]) |-> s_lands ##0 stage_r[NSH-1].res[0] == 17'h1ffff)
    else $error("round away from zero wrong");
  a_cout_gated: assert property (@(posedge CLK) disable iff (RST)
    acc && !(ctrl_r.user_prec && !ctrl_r.in_signed && !ctrl_r.out_signed && ctrl_r.drop == 2'h0)
    |-> s_lands ##0 stage_r[NSH-1].cout == '0)
    else $error("carry-out given when not allowed");
  a_apb_unmapped: assert property (@(posedge CLK) disable iff (RST)
    apb_setup && !mapped(PADDR) |=> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not flagged");
  a_out_hold: assert property (@(posedge CLK) disable iff (RST)
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
    else $error("output changed while stalled");
endmodule // vas_top

// >>> tb/vas_sink.sv
module vas_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic slow,
  input wire logic valid,
  output logic ready,
  input wire vas_pkg::vas_out_s data,
  output logic got_v,
  output vas_pkg::vas_out_s got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase_r;

  // Slow mode halves throughput so the output fifo backs up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  assign ready = !stall && !(slow && phase_r);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      got_v <= 1'b0;
      got <= '0;
    end else begin
      got_v <= valid && ready;
      if (valid && ready) begin
        got <= data;
      end
    end
  end
endmodule // vas_sink

// >>> tb/vas_bench.sv
module vas_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [10:0] ctrl;
    logic [15:0] a;
    logic [15:0] b;
    logic [3:0] sub;
    logic [3:0] cin;
    logic [16:0] r0;
    logic [16:0] r1;
    logic c0;
    logic c1;
  } vas_row_s;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic IN_VALID = 1'b0;
  logic IN_READY;
  vas_pkg::vas_in_s IN_DATA = '0;
  logic OUT_VALID;
  logic OUT_READY;
  vas_pkg::vas_out_s OUT_DATA;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic got_v;
  vas_pkg::vas_out_s got;
  vas_pkg::vas_out_s resq[$];
  int n_fail = 0;
  int checks = 0;
  // Operands go to every lane; r1/c1 apply where the lane subtracts
  vas_row_s rows[18] = '{
    '{11'h000, 16'hffff, 16'h0001, 4'ha, 4'hf, 17'h10000, 17'h00000, 1'b0, 1'b0},
    '{11'h001, 16'h0001, 16'h0002, 4'h0, 4'h0, 17'h00000, 17'h1ffff, 1'b0, 1'b0},
    '{11'h002, 16'h8000, 16'h0001, 4'h6, 4'h0, 17'h08001, 17'h07fff, 1'b0, 1'b0},
    '{11'h400, 16'h8000, 16'hffff, 4'h0, 4'h0, 17'h17fff, 17'h00000, 1'b0, 1'b0},
    '{11'h004, 16'hffff, 16'h0001, 4'h0, 4'hf, 17'h00001, 17'h00000, 1'b1, 1'b0},
    '{11'h044, 16'hffff, 16'h0001, 4'h0, 4'h0, 17'h0ffff, 17'h00000, 1'b1, 1'b0},
    '{11'h04d, 16'h0000, 16'hffff, 4'h0, 4'h0, 17'h00000, 17'h18000, 1'b0, 1'b0},
    '{11'h084, 16'hffff, 16'h0001, 4'h0, 4'h0, 17'h00000, 17'h00000, 1'b1, 1'b0},
    '{11'h104, 16'h0004, 16'h0001, 4'h0, 4'h0, 17'h00002, 17'h00000, 1'b0, 1'b0},
    '{11'h114, 16'h0004, 16'h0001, 4'h0, 4'h0, 17'h00003, 17'h00000, 1'b0, 1'b0},
    '{11'h124, 16'h0004, 16'h0001, 4'h0, 4'h0, 17'h00002, 17'h00000, 1'b0, 1'b0},
    '{11'h402, 16'h0001, 16'h0003, 4'h5, 4'h0, 17'h00004, 17'h1fffe, 1'b0, 1'b0},
    '{11'h44c, 16'h7fff, 16'h0001, 4'h0, 4'h0, 17'h07fff, 17'h00000, 1'b0, 1'b0},
    '{11'h48c, 16'h7fff, 16'h0001, 4'h0, 4'h0, 17'h18000, 17'h00000, 1'b0, 1'b0},
    '{11'h52c, 16'h0001, 16'h0000, 4'h0, 4'h0, 17'h00000, 17'h00000, 1'b0, 1'b0},
    '{11'h51c, 16'hffff, 16'h0000, 4'h0, 4'h0, 17'h1ffff, 17'h00000, 1'b0, 1'b0},
    '{11'h56d, 16'h0000, 16'h0003, 4'h0, 4'h0, 17'h00000, 17'h1fffe, 1'b0, 1'b0},
    '{11'h51d, 16'h0000, 16'h0005, 4'h0, 4'h0, 17'h00000, 17'h1fffd, 1'b0, 1'b0}};

  always #12.5 CLK = ~CLK;

  vas_top dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA));

  vas_sink sink (.clk(CLK), .rst(RST), .stall(stall), .slow(slow), .valid(OUT_VALID), .ready(OUT_READY),
    .data(OUT_DATA), .got_v(got_v), .got(got));

  always @(posedge CLK) begin
    if (got_v === 1'b1) begin
      resq.push_back(got);
    end
  end

  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_lane(input vas_pkg::vas_out_s g, input vas_pkg::vas_out_s e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One idle cycle after each transfer keeps PSEL from being driven twice per step
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, ad, wd, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] ad, input logic [31:0] e);
    logic [31:0] rd;
    logic err;
    apb(1'b0, ad, 32'h0, rd, err);
    cmp_reg(rd, e);
  endtask

  task automatic send(input vas_pkg::vas_in_s d);
    IN_VALID <= 1'b1;
    IN_DATA <= d;
    do @(posedge CLK); while (IN_READY !== 1'b1);
    IN_VALID <= 1'b0;
    IN_DATA <= ~d;
  endtask

  task automatic take(output vas_pkg::vas_out_s r);
    int n = 0;
    while (resq.size() == 0 && n < 100) begin
      @(posedge CLK);
      n++;
    end
    r = (resq.size() == 0) ? 'x : resq.pop_front();
  endtask

  function automatic vas_pkg::vas_in_s mk(input logic [15:0] a, input logic [15:0] b, input logic [3:0] s,
                                          input logic [3:0] c);
    vas_pkg::vas_in_s d;
    d.sub = s;
    d.cin = c;
    for (int l = 0; l < vas_pkg::LANES; l++) begin
      d.a[l] = a;
      d.b[l] = b;
    end
    return d;
  endfunction

  initial begin
    logic [31:0] rd;
    logic err;
    logic s;
    vas_pkg::vas_out_s r;
    vas_pkg::vas_out_s e;
    int i;
    repeat (3) @(posedge CLK);
    cmp_reg({29'h0, PREADY, IN_READY, OUT_VALID}, 32'h0);
    RST <= 1'b0;
    @(posedge CLK);
    rd_chk(vas_pkg::CTRL_ADDR, 32'h0);
    send(mk(16'h0003, 16'h0004, 4'h0, 4'h0));
    repeat (3) @(posedge CLK);
    #1 cmp_reg(32'(OUT_VALID), 32'h0);
    @(posedge CLK);
    #1 cmp_reg(32'(OUT_VALID), 32'h1);
    take(r);
    e = '0;
    for (int l = 0; l < vas_pkg::LANES; l++) e.res[l] = 17'h00007;
    cmp_lane(r, e);
    foreach (rows[k]) begin
      wr(vas_pkg::CTRL_ADDR, 32'(rows[k].ctrl));
      send(mk(rows[k].a, rows[k].b, rows[k].sub, rows[k].cin));
      take(r);
      for (int l = 0; l < vas_pkg::LANES; l++) begin
        s = rows[k].ctrl[1:0] == 2'h1 || (rows[k].ctrl[1:0] == 2'h2 && rows[k].sub[l]);
        e.res[l] = s ? rows[k].r1 : rows[k].r0;
        e.cout[l] = s ? rows[k].c1 : rows[k].c0;
      end
      cmp_lane(r, e);
    end
    apb(1'b0, vas_pkg::STATUS_ADDR, 32'h0, rd, err);
    cmp_reg(rd & 32'h80, 32'h80);
    wr(vas_pkg::STATUS_ADDR, 32'h80);
    apb(1'b0, vas_pkg::STATUS_ADDR, 32'h0, rd, err);
    cmp_reg(rd & 32'h80, 32'h0);
    wr(vas_pkg::CTRL_ADDR, 32'h2);
    stall <= 1'b1;
    fork
      begin
        for (i = 0; i < 20; i++) begin
          IN_VALID <= 1'b1;
          IN_DATA <= mk(16'(i), 16'h0100, i[3:0], 4'h0);
          do @(posedge CLK); while (IN_READY !== 1'b1);
        end
        IN_VALID <= 1'b0;
      end
      begin
        repeat (40) @(posedge CLK);
        apb(1'b0, vas_pkg::STATUS_ADDR, 32'h0, rd, err);
        cmp_reg(32'(rd[6]), 32'h0);
        cmp_reg(32'(rd[5:0]), 32'h30);
        slow <= 1'b1;
        stall <= 1'b0;
      end
    join
    for (i = 0; i < 20; i++) begin
      take(r);
      e = '0;
      for (int l = 0; l < vas_pkg::LANES; l++) e.res[l] = i[l] ? 17'(i) - 17'h00100 : 17'(i) + 17'h00100;
      cmp_lane(r, e);
    end
    slow <= 1'b0;
    rd_chk(vas_pkg::COUNT_ADDR, 32'h27);
    wr(vas_pkg::COUNT_ADDR, 32'h0);
    rd_chk(vas_pkg::COUNT_ADDR, 32'h27);
    apb(1'b0, 12'h00c, 32'h0, rd, err);
    cmp_reg({rd[31:1], err}, 32'h1);
    send(mk(16'h0001, 16'h0001, 4'h0, 4'h0));
    @(posedge CLK);
    RST <= 1'b1;
    repeat (3) @(posedge CLK);
    cmp_reg({30'h0, IN_READY, OUT_VALID}, 32'h0);
    RST <= 1'b0;
    repeat (8) @(posedge CLK);
    cmp_reg(32'(resq.size()), 32'h0);
    rd_chk(vas_pkg::CTRL_ADDR, 32'h0);
    end_of_test();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge CLK);
    n_fail++;
    end_of_test();
  end
endmodule // vas_bench
